//--- verilog/afm_pkg.sv
/*
  Package for the converter front-end control: register indices, field positions,
  reset values, select encodings and timing counts.
  Assumes a 25 MHz APB clock that also stands in for the master clock.
*/
package afm_pkg;

  // Printed offsets are not all multiples of four, so they are indices.
  localparam logic [7:0] IDX_CHOP   = 8'h09;
  localparam logic [7:0] IDX_INSEL  = 8'h2a;
  localparam logic [7:0] IDX_REFSEL = 8'h2c;
  localparam logic [7:0] IDX_OPIN   = 8'h33;
  localparam logic [7:0] IDX_ADCCTL = 8'h2f;
  localparam logic [7:0] IDX_IRQCTL = 8'h07;
  localparam logic [7:0] IDX_IRQFLG = 8'h06;
  localparam logic [7:0] IDX_FILT   = 8'h13;
  localparam logic [7:0] IDX_RESH   = 8'h10;
  localparam logic [7:0] IDX_RESM   = 8'h11;
  localparam logic [7:0] IDX_RESL   = 8'h12;

  // Writable bit masks; other bits read zero.
  localparam logic [7:0] MASK_CHOP   = 8'h0f;
  localparam logic [7:0] MASK_INSEL  = 8'h7d;
  localparam logic [7:0] MASK_REFSEL = 8'h70;
  localparam logic [7:0] MASK_OPIN   = 8'hff;
  localparam logic [7:0] MASK_ADCCTL = 8'h0f;
  localparam logic [7:0] MASK_IRQCTL = 8'h82;
  localparam logic [7:0] MASK_FILT   = 8'h0f;
  localparam logic [7:0] RST_BYTE    = 8'h00;

  // Field positions.
  localparam int B_BYPASS = 0;
  localparam int B_FILTEN = 2;
  localparam int B_POS    = 3;
  localparam int B_NEG    = 5;
  localparam int B_REFL   = 4;
  localparam int B_REFH   = 6;
  localparam int B_AZ     = 0;
  localparam int B_MODEN  = 1;
  localparam int B_GAIN   = 2;
  localparam int B_RUN    = 3;
  localparam int B_INV    = 0;
  localparam int B_NONINV = 1;
  localparam int B_OPEN   = 3;
  localparam int B_CHOP   = 0;
  localparam int B_IE     = 1;
  localparam int B_GIE    = 7;
  localparam int B_FLAG   = 1;

  // Chopper codes and periods in master clock cycles.
  localparam logic [1:0]  CHOP_POS  = 2'b00;
  localparam logic [1:0]  CHOP_NEG  = 2'b01;
  localparam logic [1:0]  CHOP_500  = 2'b10;
  localparam logic [1:0]  CHOP_1000 = 2'b11;
  localparam logic [10:0] DIV_500   = 11'd500;
  localparam logic [10:0] DIV_1000  = 11'd1000;

  // Analog select bundle driving the multiplexers.
  typedef struct packed {
    logic [1:0] pos_source_sel;
    logic       filter_enable;
    logic       filter_bypass;
    logic [1:0] neg_source_sel;
    logic       ref_high_sel;
    logic [1:0] ref_low_sel;
    logic [1:0] opamp_noninv_sel;
    logic       opamp_inv_sel;
    logic [1:0] input_gain_sel;
    logic       auto_zero;
  } afm_sel_t;

endpackage : afm_pkg

//--- verilog/afm_chopper.sv
/*
  Chopper phase generator for the op-amp input stage.
  Assumes pclk is the master clock and the enable freezes state while low.
*/
`timescale 1ns/1ps
module afm_chopper
  import afm_pkg::*;
(
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  // Control.
  input  wire logic       run,
  input  wire logic [1:0] mode,
  // Output.
  output logic            phase
);

  logic [10:0] cnt_reg, cnt_next;
  logic        ph_reg, ph_next;
  logic [10:0] period;

  always_comb begin
    period   = (mode == CHOP_1000) ? DIV_1000 : DIV_500;
    cnt_next = cnt_reg;
    ph_next  = ph_reg;
    if (!run) begin
      cnt_next = '0;
      ph_next  = (mode == CHOP_NEG); // RL11
    end else if (mode[1]) begin
      // Toggle every half period so a full cycle lasts the chosen division.
      if (cnt_reg >= (period >> 1) - 11'd1) begin
        cnt_next = '0;
        ph_next  = !ph_reg; // RL11
      end else begin
        cnt_next = cnt_reg + 11'd1;
      end
    end else begin
      cnt_next = '0;
      ph_next  = (mode == CHOP_NEG); // RL11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      ph_reg  <= 1'b0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      ph_reg  <= ph_next;
    end
  end

  assign phase = ph_reg;

endmodule : afm_chopper

//--- verilog/afm_ctrl.sv
/*
  Sigma-delta front-end control: APB register file, multiplexer selects, op-amp and
  modulator enables, comb filter run, result capture and conversion interrupt.
  Assumes the comb filter reports each new code with a one-cycle strobe on pclk.
*/
// Functional notes
// [RL1] Auto-zero ties both modulator inputs to the negative source.
// [RL2] Two-bit gain code drives the gain select: 2/3, 1, 2, 7/3.
// [RL3] Positive select routes op-amp out, op-amp plus, pin 2 or pin 3.
// [RL4] Filter enable bit turns the low-pass filter on.
// [RL5] Bypass picks the unfiltered node instead of the filtered one.
// [RL6] Negative select routes pin 2, pin 3, reference low or detect low.
// [RL7] Reference high select picks pin 4 or internal reference high.
// [RL8] Reference low select picks ground, pin 3 or internal reference low.
// [RL9] Op-amp plus select picks ground, detect high, pin 2 or pin 1.
// [RL10] Op-amp minus select picks its own output or pin 0.
// [RL11] Chopper field sets fixed orientation or chopping at divide 500/1000.
// [RL12] Op-amp enable bit powers the op-amp.
// [RL13] Interrupt reaches the CPU only with both enables set.
// [RL14] Modulator enable bit starts and stops the modulator.
// [RL15] Filter run bit releases the comb filter.
// [RL16] Software reads result bits 23 to 8 as two's complement.
// [RL17] Software calibrates offset with auto-zero, then subtracts it.
// [RL18] Software brings up supplies and bias before converting.
// [RL19] Comb filter stays in reset while filter run is zero.
// [RL20] Each new filter code raises the interrupt flag.
// [RL21] Unimplemented bits read zero and ignore writes; CHOP bits 3:2 and OPIN bits 7:4 are stored and read back.
// [RL22] Select outputs come straight from stored register bits.
`timescale 1ns/1ps
module afm_ctrl
  import afm_pkg::*;
(
  // Clock, reset and freeze.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Comb filter results.
  input  wire logic        code_valid,
  input  wire logic [23:0] code_data,
  // Analog and core controls.
  output afm_sel_t         sel,
  output logic             modulator_pos_is_neg,
  output logic             opamp_enable,
  output logic             chopper_phase,
  output logic             modulator_enable,
  output logic             filter_reset_n,
  output logic [2:0]       filter_rate,
  output logic             conv_irq
);

  logic [7:0]  insel_reg, insel_next;
  logic [7:0]  refsel_reg, refsel_next;
  logic [7:0]  opin_reg, opin_next;
  logic [7:0]  chop_reg, chop_next;
  logic [7:0]  adcctl_reg, adcctl_next;
  logic [7:0]  irqctl_reg, irqctl_next;
  logic [7:0]  filt_reg, filt_next;
  logic        flag_reg, flag_next;
  logic [23:0] res_reg, res_next;
  logic [31:0] rd_reg, rd_next;
  logic        err_reg, err_next;
  logic        rdy_reg, rdy_next;

  logic        access;
  logic        wr;
  logic        aligned;
  logic [7:0]  idx;
  logic [7:0]  wb;
  logic        hit;
  logic [7:0]  rbyte;

  // One wait state: the answer is registered, which keeps prdata off a long decode path.
  assign access  = psel && penable && !rdy_reg;
  assign idx     = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign wb      = pwdata[7:0];
  assign wr      = access && pwrite && aligned;

  always_comb begin
    hit   = aligned;
    rbyte = RST_BYTE;
    unique case (idx)
      IDX_CHOP:   rbyte = chop_reg;
      IDX_INSEL:  rbyte = insel_reg;
      IDX_REFSEL: rbyte = refsel_reg;
      IDX_OPIN:   rbyte = opin_reg;
      IDX_ADCCTL: rbyte = adcctl_reg;
      IDX_IRQCTL: rbyte = irqctl_reg;
      IDX_IRQFLG: rbyte = 8'(flag_reg) << B_FLAG;
      IDX_FILT:   rbyte = filt_reg;
      IDX_RESH:   rbyte = res_reg[23:16];
      IDX_RESM:   rbyte = res_reg[15:8];
      IDX_RESL:   rbyte = res_reg[7:0];
      default:    hit   = 1'b0;
    endcase
  end

  always_comb begin
    insel_next  = insel_reg;
    refsel_next = refsel_reg;
    opin_next   = opin_reg;
    chop_next   = chop_reg;
    adcctl_next = adcctl_reg;
    irqctl_next = irqctl_reg;
    filt_next   = filt_reg;
    flag_next   = flag_reg;
    res_next    = res_reg;
    rd_next     = rd_reg;
    err_next    = 1'b0;
    rdy_next    = access;
    if (wr && hit) begin
      unique case (idx)
        IDX_CHOP:   chop_next   = wb & MASK_CHOP;   // RL21
        IDX_INSEL:  insel_next  = wb & MASK_INSEL;  // RL21
        IDX_REFSEL: refsel_next = wb & MASK_REFSEL; // RL21
        IDX_OPIN:   opin_next   = wb & MASK_OPIN;
        IDX_ADCCTL: adcctl_next = wb & MASK_ADCCTL; // RL21
        IDX_IRQCTL: irqctl_next = wb & MASK_IRQCTL; // RL21
        IDX_IRQFLG: flag_next   = flag_reg & wb[B_FLAG];
        IDX_FILT:   filt_next   = wb & MASK_FILT;   // RL21
        default:    rd_next     = rd_reg;
      endcase
    end
    if (access) begin
      rd_next  = (hit && !pwrite) ? {24'h000000, rbyte} : 32'h00000000;
      err_next = !hit;
    end
    // A new code wins over a clear in the same cycle.
    if (code_valid && filt_reg[B_RUN]) begin
      flag_next = 1'b1;      // RL20
      res_next  = code_data;
    end
    if (!filt_reg[B_RUN]) begin
      res_next = res_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insel_reg  <= RST_BYTE;
      refsel_reg <= RST_BYTE;
      opin_reg   <= RST_BYTE;
      chop_reg   <= RST_BYTE;
      adcctl_reg <= RST_BYTE;
      irqctl_reg <= RST_BYTE;
      filt_reg   <= RST_BYTE;
      flag_reg   <= 1'b0;
      res_reg    <= '0;
      rd_reg     <= '0;
      err_reg    <= 1'b0;
      rdy_reg    <= 1'b0;
    end else if (clk_en) begin
      insel_reg  <= insel_next;
      refsel_reg <= refsel_next;
      opin_reg   <= opin_next;
      chop_reg   <= chop_next;
      adcctl_reg <= adcctl_next;
      irqctl_reg <= irqctl_next;
      filt_reg   <= filt_next;
      flag_reg   <= flag_next;
      res_reg    <= res_next;
      rd_reg     <= rd_next;
      err_reg    <= err_next;
      rdy_reg    <= rdy_next;
    end
  end

  assign pready  = rdy_reg;
  assign pslverr = err_reg;
  assign prdata  = rd_reg;

  // Selects are wired straight from the stored bits.
  assign sel.pos_source_sel   = insel_reg[B_POS +: 2];        // RL3 RL22
  assign sel.filter_enable    = insel_reg[B_FILTEN];          // RL4
  assign sel.filter_bypass    = insel_reg[B_BYPASS];          // RL5
  assign sel.neg_source_sel   = insel_reg[B_NEG +: 2];        // RL6
  assign sel.ref_high_sel     = refsel_reg[B_REFH];           // RL7
  assign sel.ref_low_sel      = refsel_reg[B_REFL +: 2];      // RL8
  assign sel.opamp_noninv_sel = opin_reg[B_NONINV +: 2];      // RL9
  assign sel.opamp_inv_sel    = opin_reg[B_INV];              // RL10
  assign sel.input_gain_sel   = adcctl_reg[B_GAIN +: 2];      // RL2
  assign sel.auto_zero        = adcctl_reg[B_AZ];             // RL1
  assign modulator_pos_is_neg = adcctl_reg[B_AZ];             // RL1
  assign opamp_enable         = opin_reg[B_OPEN];             // RL12
  assign modulator_enable     = adcctl_reg[B_MODEN];          // RL14
  assign filter_reset_n       = filt_reg[B_RUN];              // RL15 RL19
  assign filter_rate          = filt_reg[2:0];
  assign conv_irq = flag_reg && irqctl_reg[B_IE] && irqctl_reg[B_GIE]; // RL13

  afm_chopper u_chop (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .run     (opamp_enable),
    .mode    (chop_reg[B_CHOP +: 2]),
    .phase   (chopper_phase)
  );

  // Assertions.
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RL13
    conv_irq |-> (irqctl_reg[B_IE] && irqctl_reg[B_GIE] && flag_reg))
    else $error("interrupt without both enables");
  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    (clk_en && code_valid && filter_reset_n) |=> flag_reg)
    else $error("new code did not raise flag");
  filt_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL19
    !filter_reset_n |=> (!flag_reg || $past(flag_reg)))
    else $error("flag rose while filter held in reset");
  az_tie_a: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    modulator_pos_is_neg == sel.auto_zero)
    else $error("auto-zero tie mismatch");
  sel_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL22
    (clk_en && wr && idx == IDX_INSEL) |=> sel.pos_source_sel == $past(pwdata[B_POS +: 2]))
    else $error("select did not follow write");
  unimpl_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RL21
    (insel_reg & ~MASK_INSEL) == 8'h00 && (refsel_reg & ~MASK_REFSEL) == 8'h00)
    else $error("unimplemented bit set");
  mod_en_a: assert property (@(posedge pclk) disable iff (!presetn) // RL14
    (clk_en && wr && idx == IDX_ADCCTL) |=> modulator_enable == $past(pwdata[B_MODEN]))
    else $error("modulator enable mismatch");
  chop_fix_a: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    (opamp_enable && chop_reg[1:0] == CHOP_POS) [*3] |-> !chopper_phase)
    else $error("fixed orientation not held");
  ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && psel && penable && !pready) |=> pready)
    else $error("apb answer late");
  ready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && clk_en) |=> !pready)
    else $error("ready held past one cycle");
  err_unmap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && access && !hit) |=> (pslverr && prdata == 32'h00000000))
    else $error("unmapped access not refused");
  rd_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RL21
    pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  // Every select and enable field shows the written byte from the next edge on.
  gain_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    (clk_en && wr && idx == IDX_ADCCTL) |=> sel.input_gain_sel == $past(pwdata[B_GAIN +: 2]))
    else $error("gain select did not follow write");
  az_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    (clk_en && wr && idx == IDX_ADCCTL) |=> sel.auto_zero == $past(pwdata[B_AZ]))
    else $error("auto-zero did not follow write");
  filt_en_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL4
    (clk_en && wr && idx == IDX_INSEL) |=> sel.filter_enable == $past(pwdata[B_FILTEN]))
    else $error("filter enable did not follow write");
  bypass_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    (clk_en && wr && idx == IDX_INSEL) |=> sel.filter_bypass == $past(pwdata[B_BYPASS]))
    else $error("bypass did not follow write");
  neg_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    (clk_en && wr && idx == IDX_INSEL) |=> sel.neg_source_sel == $past(pwdata[B_NEG +: 2]))
    else $error("negative select did not follow write");
  refh_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    (clk_en && wr && idx == IDX_REFSEL) |=> sel.ref_high_sel == $past(pwdata[B_REFH]))
    else $error("reference high select did not follow write");
  refl_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    (clk_en && wr && idx == IDX_REFSEL) |=> sel.ref_low_sel == $past(pwdata[B_REFL +: 2]))
    else $error("reference low select did not follow write");
  noninv_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    (clk_en && wr && idx == IDX_OPIN) |=> sel.opamp_noninv_sel == $past(pwdata[B_NONINV +: 2]))
    else $error("op-amp plus select did not follow write");
  inv_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL10
    (clk_en && wr && idx == IDX_OPIN) |=> sel.opamp_inv_sel == $past(pwdata[B_INV]))
    else $error("op-amp minus select did not follow write");
  op_en_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    (clk_en && wr && idx == IDX_OPIN) |=> opamp_enable == $past(pwdata[B_OPEN]))
    else $error("op-amp enable did not follow write");
  chop_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    (clk_en && wr && idx == IDX_CHOP) |=> chop_reg[B_CHOP +: 2] == $past(pwdata[B_CHOP +: 2]))
    else $error("chopper mode did not follow write");
  run_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL15
    (clk_en && wr && idx == IDX_FILT) |=> filter_reset_n == $past(pwdata[B_RUN]))
    else $error("filter run did not follow write");
  chop_neg_a: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    (opamp_enable && chop_reg[B_CHOP +: 2] == CHOP_NEG) [*3] |-> chopper_phase)
    else $error("negative orientation not held");
  unimpl_more_a: assert property (@(posedge pclk) disable iff (!presetn) // RL21
    (chop_reg & ~MASK_CHOP) == 8'h00 && (adcctl_reg & ~MASK_ADCCTL) == 8'h00 &&
    (irqctl_reg & ~MASK_IRQCTL) == 8'h00 && (filt_reg & ~MASK_FILT) == 8'h00)
    else $error("unimplemented control bit set");
  // Results move only while the comb filter runs; a held filter keeps the last code.
  res_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL19
    !filter_reset_n |=> $stable(res_reg))
    else $error("result moved while filter held");
  res_take_a: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    (clk_en && code_valid && filter_reset_n) |=> res_reg == $past(code_data))
    else $error("new code not captured");
  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr && idx == IDX_IRQFLG && !pwdata[B_FLAG] && !(code_valid && filter_reset_n))
    |=> !flag_reg)
    else $error("flag not cleared by write");

  wr_c:   cover property (@(posedge pclk) disable iff (!presetn) wr && idx == IDX_INSEL);
  irq_c:  cover property (@(posedge pclk) disable iff (!presetn) $rose(conv_irq));
  chop_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(chopper_phase));
  az_c:   cover property (@(posedge pclk) disable iff (!presetn) $rose(sel.auto_zero));
  err_c:  cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule : afm_ctrl

//--- tb/afm_filter_model.sv
/*
  Behavioural comb filter and modulator seen from the control block.
  Assumes pclk is the master clock and gap sets the spacing of codes.
*/
`timescale 1ns/1ps
module afm_filter_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Controls from the block.
  input  wire logic        filter_reset_n,
  input  wire logic        modulator_enable,
  input  wire logic [7:0]  gap,
  // Codes to the block.
  output logic             code_valid,
  output logic [23:0]      code_data,
  output logic [23:0]      last_code
);
  logic [7:0]  cnt;
  logic [23:0] seq;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt        <= 8'h00;
      code_valid <= 1'b0;
      code_data  <= 24'h000000;
      last_code  <= 24'h000000;
      seq        <= 24'h80a5c3;
    end else if (!filter_reset_n) begin
      cnt        <= 8'h00;
      code_valid <= 1'b0;
      code_data  <= ~code_data;
    end else if (modulator_enable && cnt >= gap) begin
      cnt        <= 8'h00;
      code_valid <= 1'b1;
      code_data  <= seq;
      last_code  <= seq;
      seq        <= seq + 24'h3a5c71;
    end else begin
      cnt        <= cnt + {7'h00, modulator_enable};
      code_valid <= 1'b0;
      // Idle data keeps moving so that a stale value never passes for a code.
      code_data  <= ~code_data;
    end
  end
endmodule : afm_filter_model

//--- tb/tb_adc_frontend_mux_control.sv
/*
  Self-checking bench for the converter front-end control.
  Assumes one wait state APB slave and registers at byte address four times the index.
*/
`timescale 1ns/1ps
module tb_adc_frontend_mux_control;
  import afm_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  gap = 8'h02;
  logic        pready, pslverr, code_valid, pos_is_neg, opamp_enable, chopper_phase;
  logic        modulator_enable, filter_reset_n, conv_irq;
  logic [31:0] prdata, rd;
  logic [23:0] code_data, last_code;
  logic [2:0]  filter_rate;
  afm_sel_t    sel;
  logic        er;
  int          errors = 0;
  int          checked = 0;
  int          shadow [256];
  int          c;
  logic [31:0] rng = 32'h4b1a;
  logic [7:0]  idxs [7] = '{IDX_CHOP, IDX_INSEL, IDX_REFSEL, IDX_OPIN, IDX_ADCCTL,
                            IDX_IRQCTL, IDX_FILT};
  logic [7:0]  msks [7] = '{MASK_CHOP, MASK_INSEL, MASK_REFSEL, MASK_OPIN, MASK_ADCCTL,
                            MASK_IRQCTL, MASK_FILT};

  always #20 pclk = ~pclk;

  afm_ctrl i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .code_valid(code_valid), .code_data(code_data),
    .sel(sel), .modulator_pos_is_neg(pos_is_neg), .opamp_enable(opamp_enable),
    .chopper_phase(chopper_phase), .modulator_enable(modulator_enable),
    .filter_reset_n(filter_reset_n), .filter_rate(filter_rate), .conv_irq(conv_irq));

  afm_filter_model i_far (.pclk(pclk), .presetn(presetn), .filter_reset_n(filter_reset_n),
    .modulator_enable(modulator_enable), .gap(gap), .code_valid(code_valid),
    .code_data(code_data), .last_code(last_code));

  function logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd

  task close_out;
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task chk_rd(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task chk_pin(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t pin %h expected %h", $time, got, exp);
    end
  endtask : chk_pin

  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      close_out;
    end else begin
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task wr(input logic [7:0] idx, input logic [7:0] wd, input logic [7:0] msk);
    apb(1'b1, idx, wd);
    shadow[idx] = 32'(wd & msk);
  endtask : wr

  task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk_rd(rd, exp);
  endtask : rd_chk

  task chk_pins;
    logic [7:0] a, r, o, k, f;
    a = 8'(shadow[IDX_INSEL]);
    r = 8'(shadow[IDX_REFSEL]);
    o = 8'(shadow[IDX_OPIN]);
    k = 8'(shadow[IDX_ADCCTL]);
    f = 8'(shadow[IDX_FILT]);
    @(negedge pclk);
    chk_pin(32'(sel), 32'({a[4:3], a[2], a[0], a[6:5], r[6], r[5:4], o[2:1], o[0], k[3:2],
      k[0]}));
    chk_pin(32'(pos_is_neg), 32'(k[0]));
    chk_pin(32'({opamp_enable, modulator_enable, filter_reset_n, filter_rate}),
      32'({o[3], k[1], f[3], f[2:0]}));
  endtask : chk_pins

  task toggle_gap;
    logic p;
    c = 0;
    p = chopper_phase;
    while (chopper_phase === p && c < 1200) begin
      @(negedge pclk);
      c++;
    end
  endtask : toggle_gap

  initial begin
    #(40 * 50000);
    errors++;
    close_out;
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd_chk(idxs[i], 32'h0);
    chk_pins;
    apb(1'b0, 8'h3f, 8'h00);
    chk_rd({31'h0, er}, 32'h1);
    chk_rd(rd, 32'h0);
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < 7; i++) wr(idxs[i], 8'(rnd()), msks[i]);
      for (int i = 0; i < 7; i++) rd_chk(idxs[i], 32'(shadow[idxs[i]]));
      chk_pins;
    end
    wr(IDX_OPIN, 8'h08, MASK_OPIN);
    for (int m = 0; m < 2; m++) begin
      wr(IDX_CHOP, 8'(m), MASK_CHOP);
      repeat (4) @(negedge pclk);
      chk_pin(32'(chopper_phase), 32'(m));
    end
    for (int m = 2; m < 4; m++) begin
      wr(IDX_CHOP, 8'(m), MASK_CHOP);
      toggle_gap;
      toggle_gap;
      chk_pin(32'(c), (m == 2) ? 32'd250 : 32'd500);
    end
    // Freeze 100 edges just after a toggle; the half period stretches by the same 100.
    @(posedge pclk);
    clk_en <= 1'b0;
    repeat (100) @(posedge pclk);
    clk_en <= 1'b1;
    toggle_gap;
    chk_pin(32'(c), 32'd500);
    for (int g = 0; g < 2; g++) begin
      gap <= (g == 0) ? 8'h02 : 8'h3c;
      wr(IDX_FILT, 8'h00, MASK_FILT);
      wr(IDX_IRQCTL, 8'h82, MASK_IRQCTL);
      wr(IDX_IRQFLG, 8'h00, 8'h00);
      wr(IDX_ADCCTL, (g == 0) ? 8'h03 : 8'h02, MASK_ADCCTL);
      wr(IDX_FILT, 8'h08, MASK_FILT);
      chk_pins;
      c = 0;
      while (conv_irq !== 1'b1 && c < 300) begin
        @(negedge pclk);
        c++;
      end
      chk_pin(32'(conv_irq), 32'h1);
      wr(IDX_ADCCTL, 8'h00, MASK_ADCCTL);
      rd_chk(IDX_RESH, 32'(last_code[23:16]));
      rd_chk(IDX_RESM, 32'(last_code[15:8]));
      rd_chk(IDX_RESL, 32'(last_code[7:0]));
      rd_chk(IDX_IRQFLG, 32'h2);
      for (int j = 0; j < 3; j++) begin
        wr(IDX_IRQCTL, (j == 0) ? 8'h02 : (j == 1) ? 8'h80 : 8'h82, MASK_IRQCTL);
        @(negedge pclk);
        chk_pin(32'(conv_irq), 32'(j == 2));
      end
      wr(IDX_IRQFLG, 8'h00, 8'h00);
      @(negedge pclk);
      chk_pin(32'(conv_irq), 32'h0);
      rd_chk(IDX_IRQFLG, 32'h0);
    end
    close_out;
  end
endmodule : tb_adc_frontend_mux_control
